// File: include/dp_cfg_pkg.sv
// Purpose: Shared constants for the datapath pair paging and format block
// Assumes: 12-bit register addresses, 8-bit register data
// Notes:   Paged settings hold one copy per channel pair
package dp_cfg_pkg;
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 8;
   localparam int          SAMPLE_W          = 16;
   localparam int          FIFO_DEPTH        = 16;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] OFS_PAGE_SELECT   = 12'h008;
   localparam logic [11:0] OFS_SAMPLE_FORMAT = 12'h110;
   localparam logic [11:0] OFS_MOD_CONFIG    = 12'h111;
   localparam logic [11:0] OFS_INTERP_MODE   = 12'h112;
   localparam logic [11:0] OFS_SYNC_SWING    = 12'h2a5;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int          PAGE_SEL_LSB      = 0;
   localparam int          FORMAT_BIT        = 7;
   localparam int          SWING_BIT         = 0;
   localparam int          INVSINC_BIT       = 7;
   localparam int          MOD_TYPE_LSB      = 2;
   localparam logic [1:0]  PAGE_RST          = 2'h3;
   localparam logic [1:0]  PAGE_PAIR_A       = 2'h1;
   localparam logic [1:0]  PAGE_PAIR_B       = 2'h2;
   localparam logic [7:0]  FORMAT_RST        = 8'h00;
   localparam logic [7:0]  MOD_CONFIG_RST    = 8'h80;
   localparam logic [7:0]  INTERP_RST        = 8'h00;
   localparam logic [7:0]  SWING_RST         = 8'h00;
   localparam logic [15:0] OFFSET_FLIP       = 16'h8000;
endpackage

// File: rtl/dp_sample_fifo.sv
// Purpose: Synchronous valid/ready FIFO for the sample stream
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from a count, so no slot is wasted
`timescale 1ns/1ps
module dp_sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
         if (push && !pop) count_r <= count_r + 1'b1;
         else if (pop && !push) count_r <= count_r - 1'b1;
      end
   end
endmodule

// File: rtl/dp_pair_regs.sv
// Purpose: One channel pair's copy of the paged datapath settings
// Assumes: Write strobe already qualified by the pair select
// Notes:   Bypass flags are decoded here from the held settings
`timescale 1ns/1ps
module dp_pair_regs (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       wr_en,
   input  wire logic [11:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] format_r,
   output logic      [7:0] mod_cfg_r,
   output logic      [7:0] interp_r,
   output logic            offset_binary,
   output logic            mod_bypass,
   output logic            interp_bypass,
   output logic            invsinc_bypass
);
   wire wr_format = wr_en && (addr == dp_cfg_pkg::OFS_SAMPLE_FORMAT);
   wire wr_mod    = wr_en && (addr == dp_cfg_pkg::OFS_MOD_CONFIG);
   wire wr_interp = wr_en && (addr == dp_cfg_pkg::OFS_INTERP_MODE);

   always_ff @(posedge clk) begin
      if (rst) begin
         format_r  <= dp_cfg_pkg::FORMAT_RST;
         mod_cfg_r <= dp_cfg_pkg::MOD_CONFIG_RST;
         interp_r  <= dp_cfg_pkg::INTERP_RST;
      end else begin
         if (wr_format) format_r <= wdata;
         if (wr_mod) mod_cfg_r <= wdata;
         if (wr_interp) interp_r <= wdata;
      end
   end

   assign offset_binary  = format_r[dp_cfg_pkg::FORMAT_BIT];
   assign mod_bypass     = (mod_cfg_r[dp_cfg_pkg::MOD_TYPE_LSB +: 2] == 2'h0);
   assign interp_bypass  = (interp_r[2:0] == 3'h0);
   assign invsinc_bypass = ~mod_cfg_r[dp_cfg_pkg::INVSINC_BIT];
endmodule

// File: rtl/dp_pair_paging_format.sv
// Purpose: Pair paging, per-pair sample format and sync swing configuration
// Assumes: Registers reached by a simple addressed write/read port
// Notes:   Samples are normalised to twos complement before the FIFO
//
// Operation
// - Pair select routes writes: A, B, both
// - Paged settings held separately per channel pair
// - Format bit seven resets zero: twos complement
// - Format bit one: offset binary samples
// - Each datapath stage has its own bypass
// - Stage order: power, interpolate, modulate, adjust
// - I and Q streams handled independently
// - Stage changes alter latency; configure once
// - Sync swing bit resets normal, one high
`timescale 1ns/1ps
module dp_pair_paging_format (
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   // Register port
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [11:0] REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   output logic             REG_RVALID,
   // Sample stream, channels in pair A (ch0/ch1) and pair B (ch2/ch3)
   input  wire logic        S_VALID,
   output logic             S_READY,
   input  wire logic [15:0] S_A_I,
   input  wire logic [15:0] S_A_Q,
   input  wire logic [15:0] S_B_I,
   input  wire logic [15:0] S_B_Q,
   output logic             M_VALID,
   input  wire logic        M_READY,
   output logic      [15:0] M_A_I,
   output logic      [15:0] M_A_Q,
   output logic      [15:0] M_B_I,
   output logic      [15:0] M_B_Q,
   // Configuration seen by the downstream stages
   output logic             PAIR_A_MOD_BYPASS,
   output logic             PAIR_B_MOD_BYPASS,
   output logic             PAIR_A_INTERP_BYPASS,
   output logic             PAIR_B_INTERP_BYPASS,
   output logic             PAIR_A_INVSINC_BYPASS,
   output logic             PAIR_B_INVSINC_BYPASS,
   output logic             LINK_SYNC_REQUEST_OUT_HIGH_SWING
);
   // ----------------------------------------
   // Page select and global registers
   // ----------------------------------------
   logic [7:0] page_r;
   logic [7:0] swing_r;
   logic [7:0] rdata_r;
   logic       rvalid_r;

   wire [1:0] page_sel  = page_r[dp_cfg_pkg::PAGE_SEL_LSB +: 2];
   // Value 0 pages nothing, so a stray write is harmless
   wire       page_a    = page_sel[0];
   wire       page_b    = page_sel[1];
   wire       wr_page   = REG_WR && (REG_ADDR == dp_cfg_pkg::OFS_PAGE_SELECT);
   wire       wr_swing  = REG_WR && (REG_ADDR == dp_cfg_pkg::OFS_SYNC_SWING);
   // Both copies see the same strobe, so a both-paged write lands in one cycle
   wire       wr_a      = REG_WR && page_a;
   wire       wr_b      = REG_WR && page_b;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         page_r  <= {6'h00, dp_cfg_pkg::PAGE_RST};
         swing_r <= dp_cfg_pkg::SWING_RST;
      end else begin
         if (wr_page) page_r <= {6'h00, REG_WDATA[dp_cfg_pkg::PAGE_SEL_LSB +: 2]};
         if (wr_swing) swing_r <= {7'h00, REG_WDATA[dp_cfg_pkg::SWING_BIT]};
      end
   end

   assign LINK_SYNC_REQUEST_OUT_HIGH_SWING = swing_r[dp_cfg_pkg::SWING_BIT];

   // ----------------------------------------
   // Per-pair paged copies
   // ----------------------------------------
   logic [7:0] fmt_a, fmt_b, mod_a, mod_b, itp_a, itp_b;
   logic       obin_a, obin_b;

   dp_pair_regs u_pair_a (
      .clk            (CLK_SYS),
      .rst            (SYS_RST),
      .wr_en          (wr_a),
      .addr           (REG_ADDR),
      .wdata          (REG_WDATA),
      .format_r       (fmt_a),
      .mod_cfg_r      (mod_a),
      .interp_r       (itp_a),
      .offset_binary  (obin_a),
      .mod_bypass     (PAIR_A_MOD_BYPASS),
      .interp_bypass  (PAIR_A_INTERP_BYPASS),
      .invsinc_bypass (PAIR_A_INVSINC_BYPASS)
   );

   dp_pair_regs u_pair_b (
      .clk            (CLK_SYS),
      .rst            (SYS_RST),
      .wr_en          (wr_b),
      .addr           (REG_ADDR),
      .wdata          (REG_WDATA),
      .format_r       (fmt_b),
      .mod_cfg_r      (mod_b),
      .interp_r       (itp_b),
      .offset_binary  (obin_b),
      .mod_bypass     (PAIR_B_MOD_BYPASS),
      .interp_bypass  (PAIR_B_INTERP_BYPASS),
      .invsinc_bypass (PAIR_B_INVSINC_BYPASS)
   );

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   // Pair B copy is returned only when B alone is paged
   wire       rd_b_copy = (page_sel == dp_cfg_pkg::PAGE_PAIR_B);
   wire [7:0] rd_fmt    = rd_b_copy ? fmt_b : fmt_a;
   wire [7:0] rd_mod    = rd_b_copy ? mod_b : mod_a;
   wire [7:0] rd_itp    = rd_b_copy ? itp_b : itp_a;
   wire [7:0] rd_mux    = (REG_ADDR == dp_cfg_pkg::OFS_PAGE_SELECT)   ? page_r  :
                          (REG_ADDR == dp_cfg_pkg::OFS_SAMPLE_FORMAT) ? rd_fmt  :
                          (REG_ADDR == dp_cfg_pkg::OFS_MOD_CONFIG)    ? rd_mod  :
                          (REG_ADDR == dp_cfg_pkg::OFS_INTERP_MODE)   ? rd_itp  :
                          (REG_ADDR == dp_cfg_pkg::OFS_SYNC_SWING)    ? swing_r : 8'h00;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD;
         if (REG_RD) rdata_r <= rd_mux;
      end
   end

   assign REG_RDATA  = rdata_r;
   assign REG_RVALID = rvalid_r;

   // ----------------------------------------
   // Sample format conversion
   // ----------------------------------------
   // Flipping the sign bit maps offset binary 0x0000..0xffff onto
   // twos complement negative..positive full scale
   function automatic logic [15:0] to_twos(input logic [15:0] s, input logic obin);
      to_twos = obin ? (s ^ dp_cfg_pkg::OFFSET_FLIP) : s;
   endfunction

   // I and Q lanes are converted separately, never mixed
   wire [63:0] conv = {to_twos(S_A_I, obin_a), to_twos(S_A_Q, obin_a),
                       to_twos(S_B_I, obin_b), to_twos(S_B_Q, obin_b)};

   // ----------------------------------------
   // Sample buffer
   // ----------------------------------------
   // Register settings are not retimed against buffered samples; change
   // them only during initial configuration for fixed latency
   logic [63:0] fifo_out;

   dp_sample_fifo #(
      .WIDTH (4 * dp_cfg_pkg::SAMPLE_W),
      .DEPTH (dp_cfg_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK_SYS),
      .rst       (SYS_RST),
      .in_valid  (S_VALID),
      .in_ready  (S_READY),
      .in_data   (conv),
      .out_valid (M_VALID),
      .out_ready (M_READY),
      .out_data  (fifo_out)
   );

   assign M_A_I = fifo_out[63:48];
   assign M_A_Q = fifo_out[47:32];
   assign M_B_I = fifo_out[31:16];
   assign M_B_Q = fifo_out[15:0];
endmodule

// File: sim/dp_pair_paging_format_assertions.sv
// Purpose: Concurrent checks on the paging, bypass and swing outputs
// Assumes: Page select is tracked here from writes to the page register
// Notes:   Read answers are checked for timing, and for data at the swing register only; other data is judged in the bench
`timescale 1ns/1ps
module dp_pair_paging_format_assertions (
   input wire logic        CLK_SYS,
   input wire logic        SYS_RST,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [11:0] REG_ADDR,
   input wire logic [7:0]  REG_WDATA,
   input wire logic [7:0]  REG_RDATA,
   input wire logic        REG_RVALID,
   input wire logic        S_READY,
   input wire logic        M_VALID,
   input wire logic        M_READY,
   input wire logic [15:0] M_A_I,
   input wire logic        PAIR_A_MOD_BYPASS,
   input wire logic        PAIR_B_MOD_BYPASS,
   input wire logic        PAIR_A_INVSINC_BYPASS,
   input wire logic        LINK_SYNC_REQUEST_OUT_HIGH_SWING
);
   // ----------------------------------------
   // Page tracking and write decode
   // ----------------------------------------
   logic [1:0] page_r;
   wire logic  mod_wr   = REG_WR && REG_ADDR == 12'h111;
   wire logic  sw_wr    = REG_WR && REG_ADDR == 12'h2a5;
   wire logic  mod_none = REG_WDATA[3:2] == 2'h0;
   wire logic  sinc_on  = REG_WDATA[7];
   wire logic  sw_bit   = REG_WDATA[0];
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST)
         page_r <= 2'h3;
      else if (REG_WR && REG_ADDR == 12'h008)
         page_r <= REG_WDATA[1:0];
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   a_read_answer: assert property (REG_RD |=> REG_RVALID)
      else $error("read strobe not answered next cycle");
   a_no_stray_answer: assert property (!REG_RD |=> !REG_RVALID)
      else $error("read answer without read strobe");
   a_mod_pair_a: assert property (mod_wr && page_r[0] |=> PAIR_A_MOD_BYPASS == $past(mod_none))
      else $error("pair A modulation bypass wrong");
   a_mod_pair_b: assert property (mod_wr && page_r[1] |=> PAIR_B_MOD_BYPASS == $past(mod_none))
      else $error("pair B modulation bypass wrong");
   a_pair_a_untouched: assert property (mod_wr && !page_r[0] |=> $stable(PAIR_A_MOD_BYPASS))
      else $error("pair A changed by write not paged to it");
   a_pair_b_untouched: assert property (mod_wr && !page_r[1] |=> $stable(PAIR_B_MOD_BYPASS))
      else $error("pair B changed by write not paged to it");
   a_sinc_pair_a: assert property (mod_wr && page_r[0] |=> PAIR_A_INVSINC_BYPASS != $past(sinc_on))
      else $error("pair A inverse sinc bypass wrong");
   a_swing_follows: assert property (sw_wr |=> LINK_SYNC_REQUEST_OUT_HIGH_SWING == $past(sw_bit))
      else $error("swing output does not follow write");
   a_swing_holds: assert property (!sw_wr |=> $stable(LINK_SYNC_REQUEST_OUT_HIGH_SWING))
      else $error("swing output changed without write");
   a_swing_reset: assert property (disable iff (1'b0) SYS_RST |=> !LINK_SYNC_REQUEST_OUT_HIGH_SWING)
      else $error("swing output not normal after reset");
   a_swing_readback: assert property (REG_RD && REG_ADDR == 12'h2a5 |=>
      REG_RDATA == {7'h00, $past(LINK_SYNC_REQUEST_OUT_HIGH_SWING)})
      else $error("swing register read back wrong");
   a_out_holds: assert property (M_VALID && !M_READY |=> M_VALID && $stable(M_A_I))
      else $error("output sample dropped while stalled");
   c_pair_b_write: cover property (REG_WR && REG_ADDR == 12'h110 && page_r == 2'h2);
   c_fifo_full: cover property (!S_READY);
   c_read_answer: cover property (REG_RVALID);
endmodule
bind dp_pair_paging_format dp_pair_paging_format_assertions i_check (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .S_READY(S_READY), .M_VALID(M_VALID), .M_READY(M_READY), .M_A_I(M_A_I),
   .PAIR_A_MOD_BYPASS(PAIR_A_MOD_BYPASS), .PAIR_B_MOD_BYPASS(PAIR_B_MOD_BYPASS),
   .PAIR_A_INVSINC_BYPASS(PAIR_A_INVSINC_BYPASS),
   .LINK_SYNC_REQUEST_OUT_HIGH_SWING(LINK_SYNC_REQUEST_OUT_HIGH_SWING));

// File: sim/dp_pair_paging_format_bench.sv
// Purpose: Self-checking bench for pair paging, sample format and sync swing
// Assumes: Read answer arrives one cycle after the read strobe
// Notes:   Pair B is left in offset binary before the stream test
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module dp_pair_paging_format_bench;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, s_valid = 1'b0, m_ready = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0]  wdata = 8'h00;
   logic [15:0] s_ai = 16'h0000, s_aq = 16'h0000, s_bi = 16'h0000, s_bq = 16'h0000;
   wire  [7:0]  rdata;
   wire  [15:0] m_ai, m_aq, m_bi, m_bq;
   wire         rvalid, s_ready, m_valid, a_mod, b_mod, a_int, b_int, a_sinc, b_sinc, swing;
   int          fails = 0, compares = 0, cycles = 0;
   initial forever #4 clk = ~clk;
   dp_pair_paging_format i_dut (.CLK_SYS(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .S_VALID(s_valid), .S_READY(s_ready),
      .S_A_I(s_ai), .S_A_Q(s_aq), .S_B_I(s_bi), .S_B_Q(s_bq), .M_VALID(m_valid), .M_READY(m_ready),
      .M_A_I(m_ai), .M_A_Q(m_aq), .M_B_I(m_bi), .M_B_Q(m_bq), .PAIR_A_MOD_BYPASS(a_mod),
      .PAIR_B_MOD_BYPASS(b_mod), .PAIR_A_INTERP_BYPASS(a_int), .PAIR_B_INTERP_BYPASS(b_int),
      .PAIR_A_INVSINC_BYPASS(a_sinc), .PAIR_B_INVSINC_BYPASS(b_sinc), .LINK_SYNC_REQUEST_OUT_HIGH_SWING(swing));
   task automatic tally_and_finish();
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Strobes drop at the taking edge, so back-to-back calls never drive one signal twice per step
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rvalid, 1'b1)
      `CHK(rdata, e)
   endtask
   task automatic reset_values();
      logic [11:0] a [6] = '{12'h008, 12'h110, 12'h111, 12'h112, 12'h2a5, 12'h3ff};
      logic [7:0]  e [6] = '{8'h03, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) rd_reg(a[i], e[i]);
      `CHK({a_mod, b_mod, a_int, b_int, a_sinc, b_sinc, swing}, 7'h78)
   endtask
   task automatic paging();
      wr_reg(12'h008, 8'h02);
      wr_reg(12'h110, 8'h80);
      rd_reg(12'h110, 8'h80);
      wr_reg(12'h008, 8'h01);
      rd_reg(12'h110, 8'h00);
      wr_reg(12'h008, 8'h03);
      rd_reg(12'h110, 8'h00);
      wr_reg(12'h111, 8'h0c);
      rd_reg(12'h008, 8'h03);
      `CHK({a_mod, b_mod, a_sinc, b_sinc}, 4'h3)
      wr_reg(12'h008, 8'h01);
      wr_reg(12'h111, 8'h80);
      wr_reg(12'h008, 8'h00);
      wr_reg(12'h111, 8'h00);
      wr_reg(12'h008, 8'h02);
      wr_reg(12'h112, 8'h04);
      rd_reg(12'h111, 8'h0c);
      `CHK({a_mod, b_mod, a_sinc, b_sinc, a_int, b_int}, 6'h26)
   endtask
   task automatic swing_mode();
      wr_reg(12'h2a5, 8'hff);
      rd_reg(12'h2a5, 8'h01);
      `CHK(swing, 1'h1)
      wr_reg(12'h2a5, 8'hfe);
      rd_reg(12'h2a5, 8'h00);
      `CHK(swing, 1'h0)
   endtask
   task automatic stream();
      logic [15:0] v;
      // Pair B modulates, so it carries a quarter-rate quadrature tone; offset binary zero is 0x8000
      logic [15:0] tone [4] = '{16'hffff, 16'h8000, 16'h0000, 16'h8000};
      for (int i = 0; i < 16; i++) begin
         v = 16'(16'h1111 * i);
         @(posedge clk);
         s_valid <= 1'h1;
         s_ai <= v;
         s_aq <= ~v;
         s_bi <= tone[i % 4];
         s_bq <= tone[(i + 3) % 4];
      end
      @(posedge clk);
      s_valid <= 1'h0;
      #1;
      `CHK({s_ready, m_valid}, 2'h1)
      @(posedge clk);
      m_ready <= 1'h1;
      for (int i = 0; i < 16; i++) begin
         v = 16'(16'h1111 * i);
         #1;
         `CHK({m_valid, m_ai, m_aq}, {1'h1, v, ~v})
         `CHK({m_bi, m_bq}, {tone[i % 4] ^ 16'h8000, tone[(i + 3) % 4] ^ 16'h8000})
         @(posedge clk);
      end
      m_ready <= 1'h0;
      #1;
      `CHK(m_valid, 1'h0)
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      reset_values();
      paging();
      swing_mode();
      stream();
      tally_and_finish();
   end
endmodule
